// [pkg/psar_pkg.sv]
// constants for the phy status and auto-negotiation register bank
package psar_pkg;
  // register indexes
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
  localparam logic [4:0] IDX_ADVERT = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;
  // status field positions
  localparam int ST_ANEG_DONE = 5;
  localparam int ST_REM_FAULT = 4;
  localparam int ST_ANEG_ABLE = 3;
  localparam int ST_LINK = 2;
  localparam int ST_JABBER = 1;
  localparam int ST_EXT_CAP = 0;
  // constant ability part of status: tx fd/hd, 10 fd/hd, aneg able, extended
  localparam logic [15:0] STATUS_FIXED = 16'h7809;
  // advertisement fields
  localparam int AD_REM_FAULT = 13;
  localparam int AD_PAUSE_LO = 10;
  localparam logic [15:0] ADVERT_WMASK = 16'h2DFF;
  localparam logic [15:0] ADVERT_RESET = 16'h01E1;
  // pause encodings
  localparam logic [1:0] PAUSE_NONE = 2'h0;
  localparam logic [1:0] PAUSE_SYM = 2'h1;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PAUSE_BOTH = 2'h3;
  // partner register layout
  localparam int LP_ACK = 14;
  localparam logic [15:0] PARTNER_RESET = 16'h0001;
  localparam logic [15:0] PARTNER_WMASK = 16'h2FE0;
endpackage

// [pkg/psar_latch_if.sv]
// interface carrying latched status conditions between the bank and its latch unit
`timescale 1ns/10ps
`default_nettype none
interface psar_latch_if;
  logic linkUp;
  logic remFault;
  logic jabber;
  logic clearOnRead;
  logic linkLatched;
  logic remFaultLatched;
  logic jabberLatched;
  modport bank (output linkUp, remFault, jabber, clearOnRead,
                input linkLatched, remFaultLatched, jabberLatched);
  modport unit (input linkUp, remFault, jabber, clearOnRead,
                output linkLatched, remFaultLatched, jabberLatched);
endinterface
`default_nettype wire

// [hw/psar_status_latch.sv]
// latch-high and latch-low holding of link, fault and jabber indications
`timescale 1ns/10ps
`default_nettype none
module psar_status_latch (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // conditions and latched view
  psar_latch_if.unit lat
);
  logic linkLow_reg;
  logic faultHigh_reg;
  logic jabHigh_reg;

  // a read re-arms the latch to current condition; a new event in the read cycle still sticks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      linkLow_reg <= 1'b0;
    end else if (!lat.linkUp) begin
      linkLow_reg <= 1'b0;
    end else if (lat.clearOnRead) begin
      linkLow_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      faultHigh_reg <= 1'b0;
    end else if (lat.remFault) begin
      faultHigh_reg <= 1'b1;
    end else if (lat.clearOnRead) begin
      faultHigh_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      jabHigh_reg <= 1'b0;
    end else if (lat.jabber) begin
      jabHigh_reg <= 1'b1;
    end else if (lat.clearOnRead) begin
      jabHigh_reg <= 1'b0;
    end
  end

  assign lat.linkLatched = linkLow_reg;
  assign lat.remFaultLatched = faultHigh_reg;
  assign lat.jabberLatched = jabHigh_reg;

  // link latched low stays low while condition is down, whatever reads occur
  property p_link_low_holds;
    @(posedge clock) disable iff (!arst_n)
      !lat.linkUp |=> !linkLow_reg;
  endproperty
  a_link_low_holds: assert property (p_link_low_holds)
    else $error("link latch not low after link loss");

  // fault latch holds high until a read
  property p_fault_holds;
    @(posedge clock) disable iff (!arst_n)
      (faultHigh_reg && !lat.clearOnRead) |=> faultHigh_reg;
  endproperty
  a_fault_holds: assert property (p_fault_holds)
    else $error("fault latch dropped without read");

  property p_jab_set;
    @(posedge clock) disable iff (!arst_n)
      lat.jabber |=> jabHigh_reg;
  endproperty
  a_jab_set: assert property (p_jab_set)
    else $error("jabber not latched");
endmodule
`default_nettype wire

// [hw/psar_regs.sv]
// phy status, identifier and auto-negotiation register bank behind the management index port
`timescale 1ns/10ps
`default_nettype none
module psar_regs #(
  parameter logic [15:0] IDENT_HIGH_RESET = 16'h1234, // arbitrary identity value
  parameter logic [15:0] IDENT_LOW_RESET = 16'h5670 // arbitrary identity value
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // management index access
  input wire logic [4:0] regIndex,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // conditions from the phy datapath
  input wire logic linkUp,
  input wire logic remoteFault,
  input wire logic jabberSeen,
  input wire logic anegComplete,
  // link code word received from the partner
  input wire logic partnerWordValid,
  input wire logic [15:0] partnerWord,
  // pause result after auto-negotiation
  output logic pauseTxEn,
  output logic pauseRxEn,
  // advertisement word sent to the partner
  output logic [15:0] advertWord
);
  psar_latch_if lat ();

  logic [15:0] identHigh_reg;
  logic [15:0] identLow_reg;
  logic [15:0] advert_reg;
  logic [15:0] partner_reg;
  logic anegDone_reg;
  logic [15:0] rdData_reg;
  logic rdValid_reg;
  logic pauseTx_reg;
  logic pauseRx_reg;
  logic [15:0] statusWord;
  logic statusRead;

  // index decode, used for writes and reads
  function automatic logic hit(input logic [4:0] idx, input logic [4:0] target);
    hit = (idx == target);
  endfunction

  assign statusRead = regRead && hit(regIndex, psar_pkg::IDX_STATUS);

  // latch unit sees the raw conditions and the status read strobe
  assign lat.linkUp = linkUp;
  assign lat.remFault = remoteFault;
  assign lat.jabber = jabberSeen;
  assign lat.clearOnRead = statusRead;

  psar_status_latch u_latch (
    .clock(clock),
    .arst_n(arst_n),
    .lat(lat)
  );

  // assemble status word: fixed abilities plus live and latched bits
  always_comb begin
    statusWord = psar_pkg::STATUS_FIXED;
    statusWord[psar_pkg::ST_ANEG_DONE] = anegDone_reg;
    statusWord[psar_pkg::ST_REM_FAULT] = lat.remFaultLatched;
    statusWord[psar_pkg::ST_LINK] = lat.linkLatched;
    statusWord[psar_pkg::ST_JABBER] = lat.jabberLatched;
  end

  // completion flag follows the negotiation engine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      anegDone_reg <= 1'b0;
    end else begin
      anegDone_reg <= anegComplete;
    end
  end

  // identifier registers are fully writable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      identHigh_reg <= IDENT_HIGH_RESET;
    end else if (regWrite && hit(regIndex, psar_pkg::IDX_IDENT_HIGH)) begin
      identHigh_reg <= regWrData;
    end
  end

  // reset straight to the identity value so any written word, zero too, sticks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      identLow_reg <= IDENT_LOW_RESET;
    end else if (regWrite && hit(regIndex, psar_pkg::IDX_IDENT_LOW)) begin
      identLow_reg <= regWrData;
    end
  end

  // advertisement: reserved bits 15:14, 12, 9 masked out of writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      advert_reg <= psar_pkg::ADVERT_RESET;
    end else if (regWrite && hit(regIndex, psar_pkg::IDX_ADVERT)) begin
      advert_reg <= regWrData & psar_pkg::ADVERT_WMASK;
    end
  end

  // partner ability captured from received link code word; next page bit kept
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      partner_reg <= psar_pkg::PARTNER_RESET;
    end else if (partnerWordValid) begin
      partner_reg <= (partnerWord & psar_pkg::PARTNER_WMASK)
                     | {partnerWord[15], 1'b1, 14'h0001};
    end
  end

  // pause resolution: never both directions from a "both" advert unless symmetric agreed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pauseTx_reg <= 1'b0;
      pauseRx_reg <= 1'b0;
    end else if (!anegDone_reg) begin
      pauseTx_reg <= 1'b0;
      pauseRx_reg <= 1'b0;
    end else begin
      case (advert_reg[psar_pkg::AD_PAUSE_LO +: 2])
        psar_pkg::PAUSE_SYM: begin
          pauseTx_reg <= partner_reg[10];
          pauseRx_reg <= partner_reg[10];
        end
        psar_pkg::PAUSE_ASYM: begin
          pauseTx_reg <= (partner_reg[11:10] == psar_pkg::PAUSE_BOTH);
          pauseRx_reg <= 1'b0;
        end
        psar_pkg::PAUSE_BOTH: begin
          // symmetric wins; else asymmetric receive only
          pauseTx_reg <= partner_reg[10];
          pauseRx_reg <= partner_reg[10] || (partner_reg[11:10] == psar_pkg::PAUSE_ASYM);
        end
        default: begin
          pauseTx_reg <= 1'b0;
          pauseRx_reg <= 1'b0;
        end
      endcase
    end
  end

  // read mux, one cycle after the read strobe; unused indexes read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= 16'h0000;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRead;
      if (regRead) begin
        case (regIndex)
          psar_pkg::IDX_STATUS: rdData_reg <= statusWord;
          psar_pkg::IDX_IDENT_HIGH: rdData_reg <= identHigh_reg;
          psar_pkg::IDX_IDENT_LOW: rdData_reg <= identLow_reg;
          psar_pkg::IDX_ADVERT: rdData_reg <= advert_reg;
          psar_pkg::IDX_PARTNER: rdData_reg <= partner_reg;
          default: rdData_reg <= 16'h0000;
        endcase
      end
    end
  end

  // advertised word registered for the outside negotiation engine
  logic [15:0] advOut_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      advOut_reg <= psar_pkg::ADVERT_RESET;
    end else begin
      advOut_reg <= advert_reg;
    end
  end

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign pauseTxEn = pauseTx_reg;
  assign pauseRxEn = pauseRx_reg;
  assign advertWord = advOut_reg;

  // status read returns fixed ability bits
  property p_status_fixed;
    @(posedge clock) disable iff (!arst_n)
      statusRead |=> (rdData_reg[15:11] == 5'h0F) && rdData_reg[3] && rdData_reg[0]
                     && (rdData_reg[10:6] == 5'h00);
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("status fixed bits wrong");

  property p_aneg_done;
    @(posedge clock) disable iff (!arst_n)
      anegComplete |=> ##1 (!regRdValid || !$past(statusRead) || regRdData[5]);
  endproperty
  a_aneg_done: assert property (p_aneg_done)
    else $error("completion bit not set");

  property p_pause_one;
    @(posedge clock) disable iff (!arst_n)
      (advert_reg[11:10] == 2'h3) |-> !(pauseTx_reg && !pauseRx_reg);
  endproperty
  a_pause_one: assert property (p_pause_one)
    else $error("pause resolved to invalid mix");

  property p_advert_rsvd;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |-> (advert_reg[15:14] == 2'h0) && !advert_reg[12] && !advert_reg[9];
  endproperty
  a_advert_rsvd: assert property (p_advert_rsvd)
    else $error("advert reserved bit set");

  property p_ack_set;
    @(posedge clock) disable iff (!arst_n)
      partnerWordValid |=> partner_reg[psar_pkg::LP_ACK];
  endproperty
  a_ack_set: assert property (p_ack_set)
    else $error("acknowledge not set");

  property p_ident_write;
    @(posedge clock) disable iff (!arst_n)
      (regWrite && regIndex == psar_pkg::IDX_IDENT_HIGH) |=> identHigh_reg == $past(regWrData);
  endproperty
  a_ident_write: assert property (p_ident_write)
    else $error("identifier write lost");

  // each read strobe gives exactly one valid pulse on the next edge
  property p_rd_valid;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> (regRdValid == $past(regRead));
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read valid not one cycle after strobe");

  // read data holds between reads so a slow master may still pick it up
  property p_rd_hold;
    @(posedge clock) disable iff (!arst_n)
      !regRead |=> $stable(regRdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");

  // indexes outside the bank answer zero rather than aliasing a register
  property p_unmapped_zero;
    @(posedge clock) disable iff (!arst_n)
      (regRead && (regIndex == 5'h00 || regIndex > psar_pkg::IDX_PARTNER))
        |=> (regRdData == 16'h0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped index read not zero");

  // second identifier takes every written bit
  property p_ident_low_write;
    @(posedge clock) disable iff (!arst_n)
      (regWrite && regIndex == psar_pkg::IDX_IDENT_LOW) |=> identLow_reg == $past(regWrData);
  endproperty
  a_ident_low_write: assert property (p_ident_low_write)
    else $error("second identifier write lost");

  // writable advertisement fields take the written value
  property p_advert_write;
    @(posedge clock) disable iff (!arst_n)
      (regWrite && regIndex == psar_pkg::IDX_ADVERT)
        |=> (advert_reg[8:5] == $past(regWrData[8:5])) && (advert_reg[13] == $past(regWrData[13]))
        && (advert_reg[11:10] == $past(regWrData[11:10]));
  endproperty
  a_advert_write: assert property (p_advert_write)
    else $error("advertisement write lost");

  // partner image only moves on a received word; index writes never reach it
  property p_partner_hold;
    @(posedge clock) disable iff (!arst_n)
      !partnerWordValid |=> $stable(partner_reg);
  endproperty
  a_partner_hold: assert property (p_partner_hold)
    else $error("partner register changed without a word");

  // partner next page ability is reported as received
  property p_next_page;
    @(posedge clock) disable iff (!arst_n)
      partnerWordValid |=> partner_reg[15] == $past(partnerWord[15]);
  endproperty
  a_next_page: assert property (p_next_page)
    else $error("partner next page bit wrong");

  // partner pause field keeps the advertisement encoding
  property p_partner_pause;
    @(posedge clock) disable iff (!arst_n)
      partnerWordValid |=> partner_reg[11:10] == $past(partnerWord[11:10]);
  endproperty
  a_partner_pause: assert property (p_partner_pause)
    else $error("partner pause field wrong");

  // abilities and fault copied, reserved bit dropped, selector fixed
  property p_partner_abil;
    @(posedge clock) disable iff (!arst_n)
      partnerWordValid |=> (partner_reg[9:5] == $past(partnerWord[9:5]))
        && (partner_reg[13] == $past(partnerWord[13])) && !partner_reg[12]
        && (partner_reg[4:0] == 5'h01);
  endproperty
  a_partner_abil: assert property (p_partner_abil)
    else $error("partner ability bits wrong");

  // completion flag trails the engine by one edge
  property p_aneg_follow;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> anegDone_reg == $past(anegComplete);
  endproperty
  a_aneg_follow: assert property (p_aneg_follow)
    else $error("completion flag not following engine");

  // no pause before negotiation ends, whatever the partner claimed
  property p_pause_idle;
    @(posedge clock) disable iff (!arst_n)
      !anegDone_reg |=> !pauseTx_reg && !pauseRx_reg;
  endproperty
  a_pause_idle: assert property (p_pause_idle)
    else $error("pause enabled before completion");

  // advertising no pause never enables either direction
  property p_pause_none;
    @(posedge clock) disable iff (!arst_n)
      (anegDone_reg && advert_reg[11:10] == psar_pkg::PAUSE_NONE)
        |=> !pauseTx_reg && !pauseRx_reg;
  endproperty
  a_pause_none: assert property (p_pause_none)
    else $error("pause enabled without advertising it");

  // the word sent out trails the register by one edge
  property p_advert_out;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> advOut_reg == $past(advert_reg);
  endproperty
  a_advert_out: assert property (p_advert_out)
    else $error("advertised word not following register");
endmodule
`default_nettype wire

// [verification/psar_partner.sv]
// link partner model delivering received link code words to the bank
`timescale 1ns/10ps
`default_nettype none
module psar_partner (
  // clock
  input wire logic clock,
  // received link code word
  output logic partnerWordValid,
  output logic [15:0] partnerWord
);
  // idle at time zero
  initial begin
    partnerWordValid = 1'b0;
    partnerWord = 16'h0000;
  end
  // one-cycle delivery; word is inverted after so stale data never passes for valid
  task automatic send(input logic [15:0] word);
    @(posedge clock);
    #1 partnerWord = word;
    partnerWordValid = 1'b1;
    @(posedge clock);
    #1 partnerWordValid = 1'b0;
    partnerWord = ~word;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the phy status and auto-negotiation register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [15:0] ID_HI = 16'h2468; // arbitrary identity value
  localparam logic [15:0] ID_LO = 16'h9AB0; // arbitrary identity value
  logic clock;
  logic arst_n;
  logic [4:0] regIndex;
  logic regRead;
  logic regWrite;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic regRdValid;
  logic linkUp;
  logic remoteFault;
  logic jabberSeen;
  logic anegComplete;
  logic partnerWordValid;
  logic [15:0] partnerWord;
  logic pauseTxEn;
  logic pauseRxEn;
  logic [15:0] advertWord;
  int miscompares = 0;
  int cmpCount = 0;
  logic [15:0] rd;

  psar_regs #(.IDENT_HIGH_RESET(ID_HI), .IDENT_LOW_RESET(ID_LO)) psar_regs_i (
    .clock(clock), .arst_n(arst_n), .regIndex(regIndex), .regRead(regRead),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .linkUp(linkUp), .remoteFault(remoteFault),
    .jabberSeen(jabberSeen), .anegComplete(anegComplete),
    .partnerWordValid(partnerWordValid), .partnerWord(partnerWord),
    .pauseTxEn(pauseTxEn), .pauseRxEn(pauseRxEn), .advertWord(advertWord));
  psar_partner psar_partner_i (
    .clock(clock), .partnerWordValid(partnerWordValid), .partnerWord(partnerWord));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // indexed read: answer stands one cycle after the strobe edge
  task automatic regRd(input logic [4:0] idx, output logic [15:0] data);
    @(posedge clock);
    #1 regIndex = idx;
    regRead = 1'b1;
    @(posedge clock);
    #1 regRead = 1'b0;
    check({15'h0000, regRdValid}, 16'h0001);
    data = regRdData;
  endtask

  task automatic rdChk(input logic [4:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    regRd(idx, d);
    check(d, exp);
  endtask

  task automatic regWr(input logic [4:0] idx, input logic [15:0] data);
    @(posedge clock);
    #1 regIndex = idx;
    regWrData = data;
    regWrite = 1'b1;
    @(posedge clock);
    #1 regWrite = 1'b0;
  endtask

  // partner pause word in, resolved pause pair {tx, rx} out
  task automatic pauseChk(input logic [15:0] word, input logic [1:0] exp);
    psar_partner_i.send(word);
    repeat (3) @(posedge clock);
    #1 check({14'h0000, pauseTxEn, pauseRxEn}, {14'h0000, exp});
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog well beyond the 120 or so cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    wrap_up;
  end

  initial begin
    arst_n = 1'b0;
    regIndex = 5'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWrData = 16'h0000;
    linkUp = 1'b0;
    remoteFault = 1'b0;
    jabberSeen = 1'b0;
    anegComplete = 1'b0;
    repeat (10) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clock);
    // reset values
    rdChk(psar_pkg::IDX_STATUS, 16'h7809);
    rdChk(psar_pkg::IDX_IDENT_HIGH, ID_HI);
    rdChk(psar_pkg::IDX_IDENT_LOW, ID_LO);
    rdChk(psar_pkg::IDX_ADVERT, 16'h01E1);
    rdChk(psar_pkg::IDX_PARTNER, 16'h0001);
    check(advertWord, 16'h01E1);
    // writes to read-only and unmapped places leave nothing behind
    regWr(psar_pkg::IDX_STATUS, 16'hFFFF);
    regWr(psar_pkg::IDX_PARTNER, 16'hFFFF);
    regWr(5'h07, 16'hFFFF);
    rdChk(psar_pkg::IDX_STATUS, 16'h7809);
    rdChk(psar_pkg::IDX_PARTNER, 16'h0001);
    rdChk(5'h07, 16'h0000);
    // identifier registers are fully writable
    regWr(psar_pkg::IDX_IDENT_HIGH, 16'hFFFF);
    regWr(psar_pkg::IDX_IDENT_LOW, 16'hA5C3);
    rdChk(psar_pkg::IDX_IDENT_HIGH, 16'hFFFF);
    rdChk(psar_pkg::IDX_IDENT_LOW, 16'hA5C3);
    // reserved advertisement bits stay zero
    regWr(psar_pkg::IDX_ADVERT, 16'hFFFF);
    rdChk(psar_pkg::IDX_ADVERT, 16'h2DFF);
    check(advertWord, 16'h2DFF);
    regWr(psar_pkg::IDX_ADVERT, 16'h0000);
    rdChk(psar_pkg::IDX_ADVERT, 16'h0000);
    // every pause code, ending on both
    for (int k = 0; k < 4; k++) begin
      regWr(psar_pkg::IDX_ADVERT, {4'h0, k[1:0], 10'h1E1});
      rdChk(psar_pkg::IDX_ADVERT, {4'h0, k[1:0], 10'h1E1});
    end
    // link up; first read re-arms the latch left low since reset
    linkUp = 1'b1;
    regRd(psar_pkg::IDX_STATUS, rd);
    rdChk(psar_pkg::IDX_STATUS, 16'h780D);
    // one-cycle link drop with fault and jabber blips, all held until read
    @(posedge clock);
    #1 linkUp = 1'b0;
    remoteFault = 1'b1;
    jabberSeen = 1'b1;
    @(posedge clock);
    #1 linkUp = 1'b1;
    remoteFault = 1'b0;
    jabberSeen = 1'b0;
    repeat (4) @(posedge clock);
    rdChk(psar_pkg::IDX_STATUS, 16'h781B);
    rdChk(psar_pkg::IDX_STATUS, 16'h780D);
    // completion is a plain level
    anegComplete = 1'b1;
    rdChk(psar_pkg::IDX_STATUS, 16'h782D);
    // partner word capture: acknowledge set, read-only bits reported
    psar_partner_i.send(16'hFFFF);
    rdChk(psar_pkg::IDX_PARTNER, 16'hEFE1);
    // pause resolution with both, then symmetric, asymmetric and no pause advertised locally
    pauseChk(16'h0400, 2'b11);
    rdChk(psar_pkg::IDX_PARTNER, 16'h4401);
    pauseChk(16'h0800, 2'b01);
    rdChk(psar_pkg::IDX_PARTNER, 16'h4801);
    regWr(psar_pkg::IDX_ADVERT, 16'h05E1);
    pauseChk(16'h0400, 2'b11);
    regWr(psar_pkg::IDX_ADVERT, 16'h09E1);
    pauseChk(16'h0C00, 2'b10);
    regWr(psar_pkg::IDX_ADVERT, 16'h01E1);
    pauseChk(16'h0C00, 2'b00);
    wrap_up;
  end
endmodule
`default_nettype wire
